// >>> design/cro_pkg.sv
// constants for the return / indirect-store / rotate execution block
// assumes a 32-bit AHB-Lite register bus with byte addresses in haddr[7:0]
package cro_pkg;

  // register byte offsets
  localparam logic [7:0] CRO_OFS_CMD = 8'h00;
  localparam logic [7:0] CRO_OFS_WREG = 8'h04;
  localparam logic [7:0] CRO_OFS_STATUS = 8'h08;
  localparam logic [7:0] CRO_OFS_OPTION = 8'h0C;
  localparam logic [7:0] CRO_OFS_INTCTL = 8'h10;
  localparam logic [7:0] CRO_OFS_PWRCTL = 8'h14;
  localparam logic [7:0] CRO_OFS_PC = 8'h18;
  localparam logic [7:0] CRO_OFS_PTR0 = 8'h1C;
  localparam logic [7:0] CRO_OFS_PTR1 = 8'h20;
  localparam logic [7:0] CRO_OFS_STACK = 8'h24;
  localparam logic [7:0] CRO_OFS_MEM_ADDR = 8'h28;
  localparam logic [7:0] CRO_OFS_MEM_DATA = 8'h2C;
  localparam logic [7:0] CRO_OFS_INDIRECT = 8'h30;

  // command word fields
  localparam int CRO_CMD_OP_LSB = 0;
  localparam int CRO_CMD_K_LSB = 8;
  localparam int CRO_CMD_D_BIT = 16;
  localparam int CRO_CMD_N_BIT = 17;
  localparam int CRO_CMD_MM_LSB = 18;
  localparam int CRO_CMD_REL_BIT = 20;

  // status word fields
  localparam int CRO_ST_C_BIT = 0;
  localparam int CRO_ST_Z_BIT = 1;
  localparam int CRO_ST_BUSY_BIT = 2;
  localparam int CRO_ST_SP_LSB = 8;

  localparam int CRO_GIE_BIT = 7;
  localparam int CRO_RI_BIT = 2;

  // values after reset
  localparam logic [7:0] CRO_OPTION_RST = 8'hFF;
  localparam logic [7:0] CRO_PWRCTL_RST = 8'h04;
  localparam logic [7:0] CRO_INTCTL_RST = 8'h00;

  // instruction cycles of the two-cycle returns
  localparam int CRO_CYC_RET = 2;

  typedef enum logic [3:0] {
    CRO_OP_NOP,
    CRO_OP_OPTION,
    CRO_OP_RESET,
    CRO_OP_RETURN_FROM_INTERRUPT_OP,
    CRO_OP_RETURN,
    CRO_OP_RETURN_WITH_LITERAL_OP,
    CRO_OP_RLF,
    CRO_OP_STORE_INDIRECT_OP
  } cro_op_t;

  typedef enum logic [1:0] {
    CRO_MM_PREINC,
    CRO_MM_PREDEC,
    CRO_MM_POSTINC,
    CRO_MM_POSTDEC
  } cro_mm_t;

  typedef enum logic {
    CRO_ST_IDLE,
    CRO_ST_SECOND
  } cro_state_t;

endpackage

// >>> design/cro_ptr_unit.sv
// pointer update unit for the indirect store
// purely combinational; the caller registers the new pointer value
`timescale 1ns/1ns
module cro_ptr_unit
  import cro_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire cro_mm_t mode,
  input wire logic rel,
  input wire logic [5:0] offset,
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_next
);

  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] off_ext;

  // 16-bit sums drop the carry, so 0xFFFF+1 wraps to 0 and 0-1 to 0xFFFF
  assign inc = ptr + 16'h0001;
  assign dec = ptr - 16'h0001;
  assign off_ext = {{10{offset[5]}}, offset};

  always_comb
  begin
    eff_addr = ptr;
    ptr_next = ptr;
    if (rel)
    begin
      eff_addr = ptr + off_ext;
    end
    else
    begin
      unique case (mode)
        CRO_MM_PREINC:
        begin
          eff_addr = inc;
          ptr_next = inc;
        end
        CRO_MM_PREDEC:
        begin
          eff_addr = dec;
          ptr_next = dec;
        end
        CRO_MM_POSTINC:
        begin
          ptr_next = inc;
        end
        CRO_MM_POSTDEC:
        begin
          ptr_next = dec;
        end
      endcase
    end
  end

endmodule

// >>> design/cro_core.sv
// execution unit for returns, indirect store, option load, soft reset, rotate
// assumes one AHB-Lite master; commands are issued by writing the command word
//
// Functional notes
// - access to indirect port goes to data memory at selected pointer
// - indirect store updates the pointer before or after, per mode
// - address is pointer, pointer+1, pointer-1 or pointer+offset -32..31
// - pointers are 16 bits and wrap modulo 65536
// - pointer update in indirect store leaves all flags alone
// - option load copies working register to option register, flags kept
// - soft reset resets the core and clears the reset-instruction flag
// - return from interrupt pops stack into program counter, flags kept
// - return from interrupt sets global interrupt enable, takes 2 cycles
// - return pops stack into program counter in 2 cycles, flags kept
// - return with literal loads literal to working register, pops, 2 cycles
// - rotate left through carry of file register 0..127, carry only
// - destination 0 writes working register, 1 writes file register
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module cro_core
  import cro_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 16,
  parameter int DMEM_AW = 7
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic device_reset_req
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] w_q, option_q, intctl_q, pwrctl_q;
  logic carry_q, zero_q;
  logic [PC_W-1:0] pc_q;
  logic [15:0] ptr0_q, ptr1_q;
  logic [SP_W-1:0] sp_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [7:0] mem_q [2**DMEM_AW];
  logic [DMEM_AW-1:0] mem_addr_q;
  cro_state_t state_q;
  logic wr_q, rd_q, hreadyout_q, reset_req_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;

  // file addresses 0 and 1 are the two indirect ports
  function automatic logic [DMEM_AW-1:0] file_index(input logic [6:0] f, input logic [15:0] p0,
    input logic [15:0] p1);
    return (f == 7'h00) ? p0[DMEM_AW-1:0]
      : (f == 7'h01) ? p1[DMEM_AW-1:0] : DMEM_AW'(f);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // bus address and data phase
  logic accept, bus_wr;
  assign accept = hsel && htrans[1] && hready;
  assign bus_wr = wr_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end
    else if (rd_q)
    begin
      // one wait state: read data comes from a flop, after any write lands
      rd_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end
    else if (hready)
    begin
      wr_q <= accept && hwrite;
      rd_q <= accept && !hwrite;
      hreadyout_q <= !(accept && !hwrite);
      if (accept)
        addr_q <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  cro_op_t op;
  logic issue, is_pop, do_reset;
  logic [7:0] lit, rot_src, rot_res;
  logic [15:0] sel_ptr, eff_addr, ptr_next;
  logic [DMEM_AW-1:0] rot_idx;
  logic [PC_W-1:0] top_of_stack_entry;
  assign op = cro_op_t'(hwdata[CRO_CMD_OP_LSB +: 4]);
  assign issue = bus_wr && (addr_q == CRO_OFS_CMD) && (state_q == CRO_ST_IDLE);
  assign lit = hwdata[CRO_CMD_K_LSB +: 8];
  assign sel_ptr = hwdata[CRO_CMD_N_BIT] ? ptr1_q : ptr0_q;
  assign rot_idx = file_index(lit[6:0], ptr0_q, ptr1_q);
  assign rot_src = mem_q[rot_idx];
  assign rot_res = {rot_src[6:0], carry_q};
  assign top_of_stack_entry = stack_q[sp_q - SP_W'(1)];
  assign is_pop = issue && (op == CRO_OP_RETURN_FROM_INTERRUPT_OP || op == CRO_OP_RETURN || op == CRO_OP_RETURN_WITH_LITERAL_OP);
  assign do_reset = issue && (op == CRO_OP_RESET);
  cro_ptr_unit u_ptr (
    .ptr(sel_ptr),
    .mode(cro_mm_t'(hwdata[CRO_CMD_MM_LSB +: 2])),
    .rel(hwdata[CRO_CMD_REL_BIT]),
    .offset(hwdata[CRO_CMD_K_LSB +: 6]),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next)
  );
  ////////////////////////////////////////////////////////////////////////
  // cycle sequencing: returns hold the unit busy for a second cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= CRO_ST_IDLE;
    else
    begin
      unique case (state_q)
        CRO_ST_IDLE:
        begin
          if (is_pop)
            state_q <= CRO_ST_SECOND;
        end
        CRO_ST_SECOND:
        begin
          state_q <= CRO_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working register, option, flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      w_q <= 8'h00;
      option_q <= CRO_OPTION_RST;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (do_reset)
    begin
      w_q <= 8'h00;
      option_q <= CRO_OPTION_RST;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (issue)
    begin
      // flags change only for rotate; pointer steps never touch them
      unique case (op)
        CRO_OP_OPTION:
          option_q <= w_q;
        CRO_OP_RETURN_WITH_LITERAL_OP:
          w_q <= lit;
        CRO_OP_RLF:
        begin
          carry_q <= rot_src[7];
          if (!hwdata[CRO_CMD_D_BIT])
            w_q <= rot_res;
        end
        default: ;
      endcase
    end
    else if (bus_wr && addr_q == CRO_OFS_WREG)
      w_q <= hwdata[7:0];
    else if (bus_wr && addr_q == CRO_OFS_STATUS)
    begin
      carry_q <= hwdata[CRO_ST_C_BIT];
      zero_q <= hwdata[CRO_ST_Z_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt control and power control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      intctl_q <= CRO_INTCTL_RST;
      pwrctl_q <= CRO_PWRCTL_RST;
    end
    else if (do_reset)
    begin
      intctl_q <= CRO_INTCTL_RST;
      pwrctl_q[CRO_RI_BIT] <= 1'b0;
    end
    else if (issue && op == CRO_OP_RETURN_FROM_INTERRUPT_OP)
      intctl_q[CRO_GIE_BIT] <= 1'b1;
    else if (bus_wr && addr_q == CRO_OFS_INTCTL)
      intctl_q <= hwdata[7:0];
    else if (bus_wr && addr_q == CRO_OFS_PWRCTL)
      pwrctl_q <= hwdata[7:0];
  end
  // one-cycle request; the rest of the device resets on it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reset_req_q <= 1'b0;
    else
      reset_req_q <= do_reset;
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter and hardware stack
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_q <= '0;
      sp_q <= '0;
    end
    else if (do_reset)
    begin
      pc_q <= '0;
      sp_q <= '0;
    end
    else if (is_pop)
    begin
      pc_q <= top_of_stack_entry;
      sp_q <= sp_q - SP_W'(1);
    end
    else if (issue)
      pc_q <= pc_q + PC_W'(1);
    else if (bus_wr && addr_q == CRO_OFS_PC)
      pc_q <= hwdata[PC_W-1:0];
    else if (bus_wr && addr_q == CRO_OFS_STACK)
      sp_q <= sp_q + SP_W'(1);
  end
  // pointer wraps modulo depth; no overflow reset is modelled
  always_ff @(posedge hclk)
  begin
    if (bus_wr && addr_q == CRO_OFS_STACK && !issue)
      stack_q[sp_q] <= hwdata[PC_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end
    else if (do_reset)
    begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end
    else if (issue && op == CRO_OP_STORE_INDIRECT_OP)
    begin
      if (hwdata[CRO_CMD_N_BIT])
        ptr1_q <= ptr_next;
      else
        ptr0_q <= ptr_next;
    end
    else if (bus_wr && addr_q == CRO_OFS_PTR0)
      ptr0_q <= hwdata[15:0];
    else if (bus_wr && addr_q == CRO_OFS_PTR1)
      ptr1_q <= hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // data memory; only the low address bits of a pointer select a byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mem_addr_q <= '0;
    else if (bus_wr && addr_q == CRO_OFS_MEM_ADDR)
      mem_addr_q <= hwdata[DMEM_AW-1:0];
  end
  always_ff @(posedge hclk)
  begin
    if (issue && op == CRO_OP_STORE_INDIRECT_OP)
      mem_q[eff_addr[DMEM_AW-1:0]] <= w_q;
    else if (issue && op == CRO_OP_RLF && hwdata[CRO_CMD_D_BIT])
      mem_q[rot_idx] <= rot_res;
    else if (bus_wr && addr_q == CRO_OFS_MEM_DATA)
      mem_q[mem_addr_q] <= hwdata[7:0];
    else if (bus_wr && addr_q == CRO_OFS_INDIRECT)
      mem_q[file_index(7'h00, ptr0_q, ptr1_q)] <= hwdata[7:0];
  end
  ////////////////////////////////////////////////////////////////////////
  // read data
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (addr_q)
      CRO_OFS_WREG: rd_val = 32'(w_q);
      CRO_OFS_STATUS:
      begin
        rd_val[CRO_ST_C_BIT] = carry_q;
        rd_val[CRO_ST_Z_BIT] = zero_q;
        rd_val[CRO_ST_BUSY_BIT] = (state_q != CRO_ST_IDLE);
        rd_val[CRO_ST_SP_LSB +: SP_W] = sp_q;
      end
      CRO_OFS_OPTION: rd_val = 32'(option_q);
      CRO_OFS_INTCTL: rd_val = 32'(intctl_q);
      CRO_OFS_PWRCTL: rd_val = 32'(pwrctl_q);
      CRO_OFS_PC: rd_val = 32'(pc_q);
      CRO_OFS_PTR0: rd_val = 32'(ptr0_q);
      CRO_OFS_PTR1: rd_val = 32'(ptr1_q);
      CRO_OFS_STACK: rd_val = 32'(top_of_stack_entry);
      CRO_OFS_MEM_ADDR: rd_val = 32'(mem_addr_q);
      CRO_OFS_MEM_DATA: rd_val = 32'(mem_q[mem_addr_q]);
      CRO_OFS_INDIRECT: rd_val = 32'(mem_q[file_index(7'h00, ptr0_q, ptr1_q)]);
      default: rd_val = 32'h00000000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (rd_q)
      hrdata_q <= rd_val;
  end
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign device_reset_req = reset_req_q;

endmodule

// >>> verif/cro_core_chk.sv
// port checker for the return / indirect-store / rotate execution block
// assumes one AHB-Lite master with hready tied to hreadyout
`timescale 1ns/1ns
module cro_core_chk
  import cro_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic device_reset_req
);
  logic take;
  logic wcmd_q;
  logic rd_q;

  assign take = hsel & htrans[1] & hready;

  // data-phase tracking: command write and read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wcmd_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wcmd_q <= take & hwrite & (haddr[7:0] == CRO_OFS_CMD);
      rd_q <= take & !hwrite;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
  property p_rd_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_low_only_rd;
    !hreadyout |-> rd_q;
  endproperty
  a_low_only_rd: assert property (p_low_only_rd) else $error("stall outside read");
  property p_rdata_hold;
    !rd_q |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped;
    take && !hwrite && haddr[7:0] >= 8'h34 |=> !hreadyout ##1 hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_pulse;
    wcmd_q && hwdata[3:0] == 4'h2 |=> device_reset_req ##1 !device_reset_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse wrong");
  property p_rst_cause;
    device_reset_req |-> $past(wcmd_q && hwdata[3:0] == 4'h2);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("stray reset pulse");
endmodule

bind cro_core cro_core_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .device_reset_req(device_reset_req));

// >>> verif/cpu_return_indirect_ops_tb_top.sv
// self-checking bench for cro_core, register tasks over AHB-Lite
// assumes the design's hready is fed from its own hreadyout
`timescale 1ns/1ns
module cpu_return_indirect_ops_tb_top;
  import cro_pkg::*;
  // short alias of the working register offset used by the scenarios
  localparam logic [7:0] CRO_OFS_W = CRO_OFS_WREG;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic device_reset_req;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [15:0] p;
  logic [15:0] eff;
  logic [15:0] np;
  logic [5:0] k;
  logic rel;
  logic [7:0] pa;
  int num_errors;
  int total_checks;
  int pulses;

  assign hready = hreadyout;

  cro_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .device_reset_req(device_reset_req));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk)
    if (device_reset_req === 1'b1)
      pulses++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded: a hung slave ends the run instead of the simulator
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        num_errors++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    if (w)
      hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // file 127 is the top of the direct range
  task automatic rlf_case(input logic [31:0] st, m, d, ew, em, es);
    wr(CRO_OFS_STATUS, st);
    wr(CRO_OFS_MEM_ADDR, 32'h7F);
    wr(CRO_OFS_MEM_DATA, m);
    wr(CRO_OFS_CMD, {15'h0, d[0], 8'h7F, 8'h06});
    rd(CRO_OFS_W, ew);
    rd(CRO_OFS_MEM_DATA, em);
    rd(CRO_OFS_STATUS, es);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(CRO_OFS_PC, 32'h5);
    wr(CRO_OFS_W, 32'h33);
    wr(CRO_OFS_STATUS, 32'h3);
    wr(CRO_OFS_CMD, 32'h0);
    rd(CRO_OFS_PC, 32'h6);
    rd(CRO_OFS_W, 32'h33);
    rd(CRO_OFS_STATUS, 32'h3);
    wr(CRO_OFS_W, 32'h4F);
    wr(CRO_OFS_CMD, 32'h1);
    rd(CRO_OFS_OPTION, 32'h4F);
    rd(CRO_OFS_STATUS, 32'h3);
    rd(CRO_OFS_PC, 32'h7);
    // returns: popped entry differs per opcode, literal only for the last
    for (int op = 3; op < 6; op++)
    begin
      wr(CRO_OFS_INTCTL, 32'h0);
      wr(CRO_OFS_STACK, {21'h0, 3'(op), 8'hA5});
      wr(CRO_OFS_CMD, {16'h0, 8'hFF, 4'h0, 4'(op)});
      rd(CRO_OFS_PC, {21'h0, 3'(op), 8'hA5});
      rd(CRO_OFS_STATUS, 32'h3);
      rd(CRO_OFS_INTCTL, (op == 3) ? 32'h80 : 32'h0);
      rd(CRO_OFS_W, (op == 5) ? 32'hFF : 32'h4F);
    end
    rlf_case(32'h2, 32'hE6, 32'h0, 32'hCC, 32'hE6, 32'h3);
    rlf_case(32'h3, 32'h35, 32'h1, 32'hCC, 32'h6B, 32'h2);
    wr(CRO_OFS_STATUS, 32'h3);
    // modes from each wrap edge, then both offset extremes
    for (int i = 0; i < 6; i++)
    begin
      p = i[0] ? 16'h0000 : 16'hFFFF;
      k = (i == 4) ? 6'h20 : 6'h1F;
      rel = (i > 3);
      np = rel ? p : (i[0] ? p - 16'h1 : p + 16'h1);
      eff = rel ? p + {{10{k[5]}}, k} : (i[1] ? p : np);
      pa = i[0] ? CRO_OFS_PTR1 : CRO_OFS_PTR0;
      wr(CRO_OFS_W, 32'hA0 + 32'(i));
      wr(pa, {16'h0, p});
      wr(CRO_OFS_CMD, {11'h0, rel, 2'(i), i[0], 1'b0, 2'b0, k, 8'h07});
      rd(pa, {16'h0, np});
      rd(CRO_OFS_STATUS, 32'h3);
      wr(CRO_OFS_MEM_ADDR, {25'h0, eff[6:0]});
      rd(CRO_OFS_MEM_DATA, 32'hA0 + 32'(i));
    end
    wr(CRO_OFS_PTR0, 32'h0105);
    wr(CRO_OFS_MEM_ADDR, 32'h5);
    wr(CRO_OFS_MEM_DATA, 32'h5A);
    rd(CRO_OFS_INDIRECT, 32'h5A);
    wr(CRO_OFS_INDIRECT, 32'h3C);
    rd(CRO_OFS_MEM_DATA, 32'h3C);
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h0);
    wr(CRO_OFS_PWRCTL, 32'h7);
    wr(CRO_OFS_INTCTL, 32'h80);
    wr(CRO_OFS_CMD, 32'h2);
    rd(CRO_OFS_PWRCTL, 32'h3);
    rd(CRO_OFS_OPTION, 32'hFF);
    rd(CRO_OFS_W, 32'h0);
    rd(CRO_OFS_INTCTL, 32'h0);
    rd(CRO_OFS_PC, 32'h0);
    chk(32'(pulses), 32'h1);
    end_sim();
  end
endmodule
